/* cwos_pkg.sv */
// package for the comm watchdog / output safe-state block
// assumes a register-access front end (protocol decoder) outside this block
package cwos_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CWOS_OFF_FW_VERSION   = 16'h9c61;
    localparam logic [15:0] CWOS_OFF_WDOG_IVL     = 16'h9ca0;
    localparam logic [15:0] CWOS_OFF_SAFE_PATTERN = 16'h9ca1;
    localparam logic [15:0] CWOS_OFF_COMMAND      = 16'h9d31;
    localparam logic [15:0] CWOS_OFF_NET_RESET    = 16'h9ca6; // same numbering as the others
    // ------------------------------------------------------------
    // values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] CWOS_WDOG_DISABLED    = 16'hffff;
    localparam logic [15:0] CWOS_SAFE_RESET       = 16'h0000;
    localparam logic [15:0] CWOS_NET_RESET_KEY    = 16'h0055;
    localparam logic [15:0] CWOS_FW_VERSION_VAL   = 16'h0001; // arbitrary value
    localparam int          CWOS_CLK_HZ           = 25000000;
    localparam int          CWOS_SEC_CYCLES       = CWOS_CLK_HZ;
    localparam int          CWOS_NUM_COILS        = 15;
    localparam logic [15:0] CWOS_CMD_NO_OPERATION = 16'h0000;
    localparam logic [15:0] CWOS_CMD_REMOTE_RESET = 16'h0001;
    localparam logic [15:0] CWOS_CMD_WRITE_EN     = 16'h0002;
    localparam logic [15:0] CWOS_CMD_SYNC_SAMPLE  = 16'h0003;
    localparam logic [15:0] CWOS_CMD_COM_INIT     = 16'h0005;

    // one register access from the protocol front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cwos_req_t;
endpackage

/* cwos_sec_tick.sv */
// seconds prescaler for the watchdog
// assumes sys_clk at the package rate
`timescale 1ns/1ps
`default_nettype none
module cwos_sec_tick
    import cwos_pkg::*;
#(
    parameter int SEC_CYCLES = CWOS_SEC_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output var  logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } cwos_tick_st_t;
    cwos_tick_st_t st_ff, nxt_st;

    // free count of one second, restarted with the interval
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (restart) begin
            nxt_st.cnt = 32'h0000_0000;
        end else if (st_ff.cnt == 32'(SEC_CYCLES - 1)) begin
            nxt_st.cnt  = 32'h0000_0000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign tick = st_ff.tick;
endmodule // cwos_sec_tick
`default_nettype wire

/* cwos_top.sv */
// comm watchdog and output safe-state register block
// assumes a front end that decodes protocol messages into one-cycle accesses
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - outputs take the safe pattern after the interval elapses without traffic
// - interval of all ones disables the fallback entirely
// - interval resets to all ones, watchdog off
// - safe pattern bit n gives channel n, coils 0 to 14
// - pattern one turns output on, zero turns it off
// - safe pattern resets to zero, all outputs off
// - command register decodes no operation, remote reset, write enable, sample, com init
// - coil address 0 to e maps to channel 0 to e, read codes 01/02
// - network reset only happens when written value is 55
// - network reset only pulses net_factory_reset; interval, safe pattern and write enable keep their values
// - safe pattern is the state applied when communication is lost
module cwos_top
    import cwos_pkg::*;
#(
    parameter int SEC_CYCLES = CWOS_SEC_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire cwos_req_t   req,          // one-cycle register access
    input  wire logic        msg_valid,    // pulse: valid message to this unit
    input  wire logic        out_wr,       // pulse: host writes live outputs
    input  wire logic [14:0] out_wdata,
    input  wire logic [3:0]  coil_addr,    // discrete coil read address
    output logic      [15:0] rdata,
    output logic             rvalid,
    output logic      [14:0] dout,         // live digital outputs
    output logic             coil_bit,
    output logic             wdog_fired,   // level: outputs forced safe
    output logic             remote_reset,
    output logic             sync_sample,
    output logic             com_init,
    output logic             net_factory_reset
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ivl;
        logic [15:0] safe;
        logic        wr_en;
        logic [15:0] sec_cnt;
        logic [14:0] dout;
        logic        fired;
        logic [15:0] rdata;
        logic        rvalid;
        logic        coil_bit;
        logic        remote_reset;
        logic        sync_sample;
        logic        com_init;
        logic        net_reset;
    } cwos_st_t;
    cwos_st_t st_ff, nxt_st;
    logic     tick;

    function automatic logic hit(input cwos_req_t r, input logic [15:0] off);
        hit = r.addr == off;
    endfunction

    cwos_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .restart (msg_valid),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid       = 1'b0;
        nxt_st.remote_reset = 1'b0;
        nxt_st.sync_sample  = 1'b0;
        nxt_st.com_init     = 1'b0;
        nxt_st.net_reset    = 1'b0;
        // protected register writes need a prior write enable
        if (req.wr && st_ff.wr_en) begin
            if (hit(req, CWOS_OFF_WDOG_IVL)) begin
                nxt_st.ivl = req.wdata;
            end
            if (hit(req, CWOS_OFF_SAFE_PATTERN)) begin
                nxt_st.safe = req.wdata;
            end
        end
        if (req.wr && hit(req, CWOS_OFF_COMMAND)) begin
            unique case (req.wdata)
                CWOS_CMD_NO_OPERATION: nxt_st.wr_en = st_ff.wr_en;
                CWOS_CMD_REMOTE_RESET: nxt_st.remote_reset = st_ff.wr_en;
                CWOS_CMD_WRITE_EN:    nxt_st.wr_en = 1'b1;
                CWOS_CMD_SYNC_SAMPLE: nxt_st.sync_sample = 1'b1;
                CWOS_CMD_COM_INIT:    nxt_st.com_init = 1'b1;
                default:              nxt_st.wr_en = st_ff.wr_en;
            endcase
        end
        // network reset needs the exact key; it only pulses net_reset, settings here are kept
        if (req.wr && hit(req, CWOS_OFF_NET_RESET)
            && req.wdata == CWOS_NET_RESET_KEY) begin
            nxt_st.net_reset = 1'b1;
        end
        if (out_wr) begin
            nxt_st.dout  = out_wdata;
            nxt_st.fired = 1'b0;
        end
        // seconds count, restarted by traffic; disabled when all ones
        if (msg_valid) begin
            nxt_st.sec_cnt = 16'h0000;
        end else if (st_ff.ivl == CWOS_WDOG_DISABLED) begin
            nxt_st.sec_cnt = 16'h0000;
        end else if (!st_ff.fired) begin
            if (st_ff.sec_cnt >= st_ff.ivl) begin
                nxt_st.fired = 1'b1;
                nxt_st.dout  = st_ff.safe[14:0];
            end else if (tick) begin
                nxt_st.sec_cnt = st_ff.sec_cnt + 16'h0001;
            end
        end
        // reads
        if (req.rd) begin
            nxt_st.rvalid = 1'b1;
            if (hit(req, CWOS_OFF_FW_VERSION)) begin
                nxt_st.rdata = CWOS_FW_VERSION_VAL;
            end else if (hit(req, CWOS_OFF_WDOG_IVL)) begin
                nxt_st.rdata = st_ff.ivl;
            end else if (hit(req, CWOS_OFF_SAFE_PATTERN)) begin
                nxt_st.rdata = st_ff.safe;
            end else begin
                nxt_st.rdata = 16'h0000; // write-only and unmapped read zero
            end
        end
        // coil n is channel n, bit 15 has no coil
        nxt_st.coil_bit = (coil_addr < 4'hf) ? st_ff.dout[coil_addr] : 1'b0;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff      <= '0;
            st_ff.ivl  <= CWOS_WDOG_DISABLED;
            st_ff.safe <= CWOS_SAFE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata             = st_ff.rdata;
    assign rvalid            = st_ff.rvalid;
    assign dout              = st_ff.dout;
    assign coil_bit          = st_ff.coil_bit;
    assign wdog_fired        = st_ff.fired;
    assign remote_reset      = st_ff.remote_reset;
    assign sync_sample       = st_ff.sync_sample;
    assign com_init          = st_ff.com_init;
    assign net_factory_reset = st_ff.net_reset;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    disabled_no_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_ff.ivl == CWOS_WDOG_DISABLED && !st_ff.fired |=> !st_ff.fired)
        else $error("watchdog fired while disabled");
    fire_safe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(st_ff.fired) |-> st_ff.dout == $past(st_ff.safe[14:0]))
        else $error("outputs not set to safe pattern");
    msg_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        msg_valid |=> st_ff.sec_cnt == 16'h0000)
        else $error("interval not restarted");
    key_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_ff.net_reset |-> $past(req.wr && req.wdata == CWOS_NET_RESET_KEY))
        else $error("network reset without key");
    write_protect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !st_ff.wr_en |=> $stable(st_ff.ivl) && $stable(st_ff.safe))
        else $error("protected write accepted");
    wr_en_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.wr && req.addr == CWOS_OFF_COMMAND && req.wdata == CWOS_CMD_WRITE_EN
        |=> st_ff.wr_en)
        else $error("write enable command lost");
    coil_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        coil_addr == 4'h0 |=> st_ff.coil_bit == $past(st_ff.dout[0]))
        else $error("coil mapping wrong");
    ivl_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.rd && req.addr == CWOS_OFF_WDOG_IVL |=> rvalid && rdata == $past(st_ff.ivl))
        else $error("interval read wrong");
endmodule // cwos_top
`default_nettype wire

/* cwos_host.sv */
// remote host model: one-cycle register accesses and message pulses
// assumes one bench process calls its tasks, never two at once
`timescale 1ns/1ps
`default_nettype none
module cwos_host
    import cwos_pkg::*;
#(
    parameter int SEC_CYCLES = 10
) (
    input  wire logic      sys_clk,
    output var  cwos_req_t req,
    output var  logic      msg_valid
);
    initial begin
        req       = '0;
        msg_valid = 1'b0;
    end
    // each access is a valid message too, so it restarts the watchdog
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk) #1;
        req       = {w, !w, a, d};
        msg_valid = 1'b1;
        @(posedge sys_clk) #1;
        // released lines show inverted junk, never the last value
        req       = {1'b0, 1'b0, ~a, ~d};
        msg_valid = 1'b0;
    endtask
    // message with no register access
    task automatic ping();
        @(posedge sys_clk) #1;
        msg_valid = 1'b1;
        @(posedge sys_clk) #1;
        msg_valid = 1'b0;
    endtask
    // network reset: settle time after power-up, then the keyed write
    task automatic net_reset(input logic [15:0] key);
        repeat (30 * SEC_CYCLES) @(posedge sys_clk);
        access(1'b1, CWOS_OFF_NET_RESET, key);
    endtask
endmodule // cwos_host
`default_nettype wire

/* cwos_top_tb.sv */
// self-checking bench for the watchdog / safe-state block
// assumes the host model drives req and msg_valid; bench drives the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module cwos_top_tb;
    import cwos_pkg::*;
    localparam int SC = 10; // short second keeps the run brief
    logic sys_clk = 1'b0, rst_n = 1'b0, out_wr = 1'b0;
    logic [14:0] out_wdata = 15'h0000;
    logic [3:0]  coil_addr = 4'h0;
    logic [15:0] rdata;
    logic [14:0] dout;
    logic rvalid, coil_bit, wdog_fired, remote_reset, sync_sample, com_init, net_rst;
    cwos_req_t req;
    logic msg_valid;
    int n_errors = 0, checks_done = 0, cycles = 0;
    initial forever #20 sys_clk = ~sys_clk;
    cwos_host #(.SEC_CYCLES(SC)) u_host (.sys_clk(sys_clk), .req(req), .msg_valid(msg_valid));
    cwos_top #(.SEC_CYCLES(SC)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
        .msg_valid(msg_valid), .out_wr(out_wr), .out_wdata(out_wdata), .coil_addr(coil_addr),
        .rdata(rdata), .rvalid(rvalid), .dout(dout), .coil_bit(coil_bit),
        .wdog_fired(wdog_fired), .remote_reset(remote_reset), .sync_sample(sync_sample),
        .com_init(com_init), .net_factory_reset(net_rst));
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard: the whole run needs well under this
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        u_host.access(1'b0, a, 16'h0000);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask
    // an output write is host traffic too, so the message pulse rides along;
    // without it the stale count would refire the watchdog at once
    task automatic set_out(input logic [14:0] v);
        fork
            u_host.ping();
            begin
                @(posedge sys_clk) #1;
                out_wr = 1'b1;
                out_wdata = v;
                @(posedge sys_clk) #1;
                out_wr = 1'b0;
            end
        join
    endtask
    task automatic wait_fire(input int lo);
        int i;
        repeat (lo) @(posedge sys_clk);
        #1;
        `CHK(wdog_fired, 1'b0)
        // sample off the edge; a few cycles of slack for the tick pipeline
        for (i = 0; i < 4 && wdog_fired !== 1'b1; i++) begin
            @(posedge sys_clk) #1;
        end
        `CHK(wdog_fired, 1'b1)
    endtask
    // reset values and write protection before any enable
    task automatic t_reset_protect();
        `CHK(dout, 15'h0000)
        rd_chk(CWOS_OFF_WDOG_IVL, CWOS_WDOG_DISABLED);
        rd_chk(CWOS_OFF_SAFE_PATTERN, CWOS_SAFE_RESET);
        rd_chk(CWOS_OFF_FW_VERSION, CWOS_FW_VERSION_VAL);
        rd_chk(CWOS_OFF_COMMAND, 16'h0000);
        rd_chk(16'h1234, 16'h0000);
        u_host.access(1'b1, CWOS_OFF_WDOG_IVL, 16'h0003);
        rd_chk(CWOS_OFF_WDOG_IVL, CWOS_WDOG_DISABLED);
        u_host.access(1'b1, CWOS_OFF_COMMAND, CWOS_CMD_REMOTE_RESET);
        `CHK(remote_reset, 1'b0)
    endtask
    // every command code, after write enable
    task automatic t_commands();
        logic [15:0] c [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0005};
        logic [2:0]  e [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
        u_host.access(1'b1, CWOS_OFF_COMMAND, CWOS_CMD_WRITE_EN);
        for (int i = 0; i < 4; i++) begin
            u_host.access(1'b1, CWOS_OFF_COMMAND, c[i]);
            `CHK({remote_reset, sync_sample, com_init}, e[i])
        end
    endtask
    // fallback to the safe pattern, restart by traffic, coil map
    task automatic t_watchdog();
        u_host.access(1'b1, CWOS_OFF_SAFE_PATTERN, 16'h5a5a);
        rd_chk(CWOS_OFF_SAFE_PATTERN, 16'h5a5a);
        u_host.access(1'b1, CWOS_OFF_WDOG_IVL, 16'h0003);
        wait_fire(3 * SC);
        `CHK(dout, 15'h5a5a)
        set_out(15'h4c31);
        `CHK(wdog_fired, 1'b0)
        for (int i = 0; i < 6; i++) begin
            repeat (14) @(posedge sys_clk);
            u_host.ping();
            `CHK(wdog_fired, 1'b0)
        end
        wait_fire(3 * SC);
        set_out(15'h4c31);
        for (int a = 0; a < 16; a++) begin
            coil_addr = 4'(a);
            @(posedge sys_clk) #1;
            `CHK(coil_bit, (a < 15) ? out_wdata[a] : 1'b0)
        end
        u_host.access(1'b1, CWOS_OFF_WDOG_IVL, CWOS_WDOG_DISABLED);
        repeat (120) @(posedge sys_clk);
        `CHK(wdog_fired, 1'b0)
        `CHK(dout, 15'h4c31)
    endtask
    // network reset only with the right key
    task automatic t_net_reset();
        u_host.net_reset(16'h0054);
        `CHK(net_rst, 1'b0)
        u_host.net_reset(CWOS_NET_RESET_KEY);
        `CHK(net_rst, 1'b1)
        @(posedge sys_clk) #1;
        `CHK(net_rst, 1'b0)
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_reset_protect();
        t_commands();
        t_watchdog();
        t_net_reset();
        finish_test();
    end
endmodule // cwos_top_tb
`default_nettype wire
